// ### logic/rbc_consts.svh
`ifndef RBC_CONSTS_SVH
`define RBC_CONSTS_SVH
// ==========================================
// register byte offsets
`define RBC_OFF_BACKUP_CTL 8'h00
`define RBC_OFF_SUBCLK_PWR 8'h04
`define RBC_OFF_PROTECT 8'h08
`define RBC_OFF_STATUS 8'h0C
`define RBC_OFF_BACKUP_SET 8'h10
`define RBC_OFF_BACKUP_CLR 8'h14
`define RBC_OFF_SUBCLK_SET 8'h18
`define RBC_OFF_SUBCLK_CLR 8'h1C
// ==========================================
// field positions
`define RBC_BIT_ALLOW 0
`define RBC_BIT_ENTER 1
`define RBC_BIT_LOWPWR 0
`define RBC_BIT_ST_MODE 0
`define RBC_BIT_ST_ARMED 1
`define RBC_BIT_ST_ERR 2
// ==========================================
// reset values and bus codes
`define RBC_RST_BYTE 8'h00
`define RBC_RST_WORD 32'h0000_0000
`define RBC_HTRANS_NONSEQ 2'h2
`define RBC_HSIZE_BYTE 3'h0
`define RBC_HSIZE_HALF 3'h1
`define RBC_HSIZE_WORD 3'h2
`define RBC_HRESP_OKAY 1'b0
`endif

// ### logic/rbc_pkg.sv
package rbc_pkg;
  // ==========================================
  // protected write sequencer
  typedef enum logic [0:0] {
    RBC_PROT_IDLE = 1'b0,
    RBC_PROT_ARMED = 1'b1
  } rbc_prot_t;

  // ==========================================
  // ahb data phase record
  typedef struct packed {
    logic valid;
    logic write;
    logic lane0;
    logic [7:0] offset;
  } rbc_dphase_t;

  // ==========================================
  // stored control bits
  typedef struct packed {
    logic allow;
    logic enter;
    logic lowpwr;
  } rbc_ctl_t;
endpackage : rbc_pkg

// ### logic/rbc_top.sv
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "rbc_consts.svh"
// Summary of operation
// - control registers change only after the protect unlock write; watchdog exit clears backup_enter and subosc_low_power_sel without it.
// - byte writes and single-bit set or clear writes both supported.
// - control registers clear only on backup supply power-on reset; watchdog exit also clears backup_enter and subosc_low_power_sel.
// - backup_allow 0 forbids backup mode, 1 permits it.
// - backup_enter 1 requests backup mode, 0 leaves it.
// - backup_enter 1 selects divided subclock, stops irq, pin, correction.
// - backup_enter stores without backup_allow but mode stays off.
// - subosc_low_power_sel 0 normal oscillation, 1 ultra low power.
// - mode active with allow and enter; low power select optional.
// - mode released once backup_enter or backup_allow clears; low power select ignored.
// - watchdog reset cannot be stopped; reset flow then exits mode.
// - watchdog irq in backup mode without external reset exits mode.
// - counter and subclock keep running from the backup supply.
module rbc_top
  import rbc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic sys_reset_in,
  input wire logic ext_reset_in,
  input wire logic watchdog_irq_in,
  output logic backup_mode_out,
  output logic rtc_clk_div_sel_out,
  output logic rtc_irq_en_out,
  output logic rtc_pin_out_en_out,
  output logic rtc_err_corr_en_out,
  output logic subosc_low_power_sel_out
);

  // ==========================================
  // reset release
  logic rst_meta;
  logic rst_b_sync;

  // backup supply power-on reset is the only reset that clears the control bits
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta <= 1'b0;
      rst_b_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_b_sync <= rst_meta;
    end
  end

  // ==========================================
  // helpers
  function automatic logic lane0_hit(input logic [2:0] size, input logic [1:0] lo);
    logic hit;
    hit = 1'b0;
    unique case (size)
      `RBC_HSIZE_BYTE: hit = (lo == 2'h0);
      `RBC_HSIZE_HALF: hit = (lo[1] == 1'b0);
      `RBC_HSIZE_WORD: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : lane0_hit

  function automatic logic is_ctl_target(input logic [7:0] off);
    return (off == `RBC_OFF_BACKUP_CTL) || (off == `RBC_OFF_SUBCLK_PWR) ||
           (off == `RBC_OFF_BACKUP_SET) || (off == `RBC_OFF_BACKUP_CLR) ||
           (off == `RBC_OFF_SUBCLK_SET) || (off == `RBC_OFF_SUBCLK_CLR);
  endfunction : is_ctl_target

  function automatic logic [31:0] read_mux(input logic [7:0] off, input rbc_ctl_t c,
                                           input logic mode, input logic armed,
                                           input logic err);
    logic [31:0] d;
    d = `RBC_RST_WORD;
    unique case (off)
      `RBC_OFF_BACKUP_CTL, `RBC_OFF_BACKUP_SET, `RBC_OFF_BACKUP_CLR:
      begin
        d[`RBC_BIT_ALLOW] = c.allow;
        d[`RBC_BIT_ENTER] = c.enter;
      end
      `RBC_OFF_SUBCLK_PWR, `RBC_OFF_SUBCLK_SET, `RBC_OFF_SUBCLK_CLR:
        d[`RBC_BIT_LOWPWR] = c.lowpwr;
      `RBC_OFF_STATUS:
      begin
        d[`RBC_BIT_ST_MODE] = mode;
        d[`RBC_BIT_ST_ARMED] = armed;
        d[`RBC_BIT_ST_ERR] = err;
      end
      default: d = `RBC_RST_WORD;
    endcase
    return d;
  endfunction : read_mux

  // ==========================================
  // ahb-lite address phase capture
  rbc_dphase_t dphase;
  rbc_dphase_t next_dphase;
  logic addr_take;

  assign addr_take = hsel_in && hready_in && (htrans_in == `RBC_HTRANS_NONSEQ);

  always_comb
  begin
    next_dphase.valid = addr_take;
    next_dphase.write = hwrite_in;
    next_dphase.lane0 = lane0_hit(hsize_in, haddr_in[1:0]);
    next_dphase.offset = {haddr_in[7:2], 2'b00};
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_sync)
  begin
    if (!rst_b_sync)
    begin
      dphase <= '0;
    end
    else
    begin
      dphase <= next_dphase;
    end
  end

  logic wr_now;
  logic [7:0] wr_byte;

  assign wr_now = dphase.valid && dphase.write;
  assign wr_byte = hwdata_in[7:0];

  // ==========================================
  // protected write sequencer
  rbc_prot_t prot;
  rbc_prot_t next_prot;
  logic ctl_wr_ok;
  logic err;
  logic next_err;

  always_comb
  begin
    next_prot = prot;
    ctl_wr_ok = 1'b0;
    next_err = err;
    if (wr_now)
    begin
      if (dphase.offset == `RBC_OFF_PROTECT)
      begin
        next_prot = RBC_PROT_ARMED;
      end
      else
      begin
        // any other write consumes the unlock, so a stray store cannot land later
        next_prot = RBC_PROT_IDLE;
        // clear first so that a violation in the same cycle keeps the flag
        if ((dphase.offset == `RBC_OFF_STATUS) && dphase.lane0 &&
            wr_byte[`RBC_BIT_ST_ERR])
        begin
          next_err = 1'b0;
        end
        if (is_ctl_target(dphase.offset))
        begin
          ctl_wr_ok = (prot == RBC_PROT_ARMED) && dphase.lane0;
          if (prot != RBC_PROT_ARMED)
          begin
            next_err = 1'b1;
          end
        end
      end
    end
    // a system reset of the main domain drops a pending unlock only
    if (sys_reset_in)
    begin
      next_prot = RBC_PROT_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_sync)
  begin
    if (!rst_b_sync)
    begin
      prot <= RBC_PROT_IDLE;
      err <= 1'b0;
    end
    else
    begin
      prot <= next_prot;
      err <= next_err;
    end
  end

  // ==========================================
  // backup control bits
  rbc_ctl_t ctl;
  rbc_ctl_t next_ctl;
  logic mode;
  logic next_mode;
  logic wdt_exit;

  // watchdog irq only pulls the block out when no external reset owns the exit
  assign wdt_exit = mode && watchdog_irq_in && !ext_reset_in;

  always_comb
  begin
    next_ctl = ctl;
    if (ctl_wr_ok)
    begin
      unique case (dphase.offset)
        `RBC_OFF_BACKUP_CTL:
        begin
          next_ctl.allow = wr_byte[`RBC_BIT_ALLOW];
          next_ctl.enter = wr_byte[`RBC_BIT_ENTER];
        end
        `RBC_OFF_BACKUP_SET:
        begin
          next_ctl.allow = ctl.allow | wr_byte[`RBC_BIT_ALLOW];
          next_ctl.enter = ctl.enter | wr_byte[`RBC_BIT_ENTER];
        end
        `RBC_OFF_BACKUP_CLR:
        begin
          next_ctl.allow = ctl.allow & ~wr_byte[`RBC_BIT_ALLOW];
          next_ctl.enter = ctl.enter & ~wr_byte[`RBC_BIT_ENTER];
        end
        `RBC_OFF_SUBCLK_PWR:
          next_ctl.lowpwr = wr_byte[`RBC_BIT_LOWPWR];
        `RBC_OFF_SUBCLK_SET:
          next_ctl.lowpwr = ctl.lowpwr | wr_byte[`RBC_BIT_LOWPWR];
        `RBC_OFF_SUBCLK_CLR:
          next_ctl.lowpwr = ctl.lowpwr & ~wr_byte[`RBC_BIT_LOWPWR];
        default:
          next_ctl = ctl;
      endcase
    end
    if (wdt_exit)
    begin
      next_ctl.enter = 1'b0;
      next_ctl.lowpwr = 1'b0;
    end
    // enter stores even without allow; the mode gate below keeps mode off, but the rtc outputs still follow enter
    next_mode = next_ctl.allow && next_ctl.enter;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_sync)
  begin
    if (!rst_b_sync)
    begin
      ctl <= '0;
      mode <= 1'b0;
    end
    else
    begin
      ctl <= next_ctl;
      mode <= next_mode;
    end
  end

  // ==========================================
  // read data, taken at the address phase from the coming values
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = rdata;
    if (addr_take && !hwrite_in)
    begin
      next_rdata = read_mux({haddr_in[7:2], 2'b00}, next_ctl, next_mode,
                            (next_prot == RBC_PROT_ARMED), next_err);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_sync)
  begin
    if (!rst_b_sync)
    begin
      rdata <= `RBC_RST_WORD;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // ==========================================
  // outputs
  assign hrdata_out = rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = `RBC_HRESP_OKAY;
  assign backup_mode_out = mode;
  // counter keeps its own clock and count; only these features follow enter
  assign rtc_clk_div_sel_out = ctl.enter;
  assign rtc_irq_en_out = !ctl.enter;
  assign rtc_pin_out_en_out = !ctl.enter;
  assign rtc_err_corr_en_out = !ctl.enter;
  assign subosc_low_power_sel_out = ctl.lowpwr;

endmodule : rbc_top

// ### verif/rbc_top_props.sv
`timescale 1ns/100ps
// ==========================================
// port checks for backup mode control
module rbc_top_props (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic ext_reset_in,
  input wire logic watchdog_irq_in,
  input wire logic backup_mode_out,
  input wire logic rtc_clk_div_sel_out,
  input wire logic rtc_irq_en_out,
  input wire logic rtc_pin_out_en_out,
  input wire logic rtc_err_corr_en_out,
  input wire logic subosc_low_power_sel_out
);
  logic wr_dp;
  logic next_wr_dp;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // a write lands only at the edge closing its data phase
  always_comb next_wr_dp = hsel_in && hready_in && htrans_in == 2'h2 && hwrite_in;
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
      wr_dp <= 1'b0;
    else
      wr_dp <= next_wr_dp;
  irq_follow_a: assert property (rtc_irq_en_out == !rtc_clk_div_sel_out)
    else $error("irq enable not inverse of enter");
  pin_follow_a: assert property (rtc_pin_out_en_out == !rtc_clk_div_sel_out)
    else $error("pin enable not inverse of enter");
  corr_follow_a: assert property (rtc_err_corr_en_out == !rtc_clk_div_sel_out)
    else $error("correction enable not inverse of enter");
  mode_enter_a: assert property (backup_mode_out |-> rtc_clk_div_sel_out)
    else $error("mode active without enter");
  wdog_exit_a: assert property (backup_mode_out && watchdog_irq_in && !ext_reset_in
    |=> !backup_mode_out && !rtc_clk_div_sel_out && !subosc_low_power_sel_out)
    else $error("watchdog did not exit mode");
  wdog_hold_a: assert property (backup_mode_out && watchdog_irq_in && ext_reset_in
    && !wr_dp |=> backup_mode_out) else $error("mode left under external reset");
  ctl_hold_a: assert property (!wr_dp && !watchdog_irq_in |=> $stable(backup_mode_out)
    && $stable(rtc_clk_div_sel_out) && $stable(subosc_low_power_sel_out))
    else $error("control changed without a write");
  bus_okay_a: assert property (hsel_in |-> hreadyout_out && !hresp_out)
    else $error("bus not ready or not okay");
endmodule : rbc_top_props

bind rbc_top rbc_top_props i_props (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .ext_reset_in(ext_reset_in),
  .watchdog_irq_in(watchdog_irq_in), .backup_mode_out(backup_mode_out),
  .rtc_clk_div_sel_out(rtc_clk_div_sel_out), .rtc_irq_en_out(rtc_irq_en_out),
  .rtc_pin_out_en_out(rtc_pin_out_en_out), .rtc_err_corr_en_out(rtc_err_corr_en_out),
  .subosc_low_power_sel_out(subosc_low_power_sel_out));

// ### verif/rbc_top_bench.sv
`timescale 1ns/100ps
module rbc_top_bench;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic hsel_in, hwrite_in, sys_reset_in, ext_reset_in, watchdog_irq_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  logic hreadyout_out, hresp_out, backup_mode_out, rtc_clk_div_sel_out;
  logic rtc_irq_en_out, rtc_pin_out_en_out, rtc_err_corr_en_out, subosc_low_power_sel_out;
  logic [5:0] pins;
  int bad_count = 0;
  int n_checks = 0;
  // write addr, write data, read addr, read value, pins
  localparam logic [37:0] ROWS [10] = '{
    {8'h00, 8'h01, 8'h00, 8'h01, 6'h0E}, {8'h00, 8'h03, 8'h00, 8'h03, 6'h30},
    {8'h04, 8'h01, 8'h04, 8'h01, 6'h31}, {8'h14, 8'h02, 8'h00, 8'h01, 6'h0F},
    {8'h1C, 8'h01, 8'h04, 8'h00, 6'h0E}, {8'h00, 8'h00, 8'h00, 8'h00, 6'h0E},
    {8'h00, 8'h02, 8'h00, 8'h02, 6'h10}, {8'h10, 8'h01, 8'h00, 8'h03, 6'h30},
    {8'h18, 8'h01, 8'h18, 8'h01, 6'h31}, {8'h00, 8'h00, 8'h00, 8'h00, 6'h0F}};
  assign pins = {backup_mode_out, rtc_clk_div_sel_out, rtc_irq_en_out, rtc_pin_out_en_out,
    rtc_err_corr_en_out, subosc_low_power_sel_out};
  always #25 clk_sys_in = ~clk_sys_in;
  rbc_top i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .sys_reset_in(sys_reset_in),
    .ext_reset_in(ext_reset_in), .watchdog_irq_in(watchdog_irq_in),
    .backup_mode_out(backup_mode_out), .rtc_clk_div_sel_out(rtc_clk_div_sel_out),
    .rtc_irq_en_out(rtc_irq_en_out), .rtc_pin_out_en_out(rtc_pin_out_en_out),
    .rtc_err_corr_en_out(rtc_err_corr_en_out),
    .subosc_low_power_sel_out(subosc_low_power_sel_out));
  // ==========================================
  // report and compare
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_pins(input logic [5:0] e);
    #1;
    n_checks++;
    if (pins !== e)
    begin
      bad_count++;
      $display("MISMATCH pins expected %b seen %b", e, pins);
    end
  endtask : chk_pins
  // ==========================================
  // bus master
  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (hreadyout_out !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      stop_test();
    end
  endtask : rdy
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel_in <= 1'b1;
    haddr_in <= {24'h00_0000, a};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    hsize_in <= 3'h2;
    rdy();
    htrans_in <= 2'h0;
    hwdata_in <= {24'h00_0000, d};
    rdy();
    rd = hrdata_out;
  endtask : xfer
  task automatic pw(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, 8'h08, 8'h00);
    xfer(1'b1, a, d);
  endtask : pw
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk_reg(nm, {24'h00_0000, e}, rd);
  endtask : rdchk
  // ==========================================
  // main sequence
  initial
  begin
    hsel_in = 1'b0;
    haddr_in = 32'h0000_0000;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hsize_in = 3'h0;
    hwdata_in = 32'h0000_0000;
    sys_reset_in = 1'b0;
    ext_reset_in = 1'b0;
    watchdog_irq_in = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk_pins(6'h0E);
    rdchk("ctl", 8'h00, 8'h00);
    rdchk("subclk", 8'h04, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      pw(ROWS[i][37:30], ROWS[i][29:22]);
      rdchk("row", ROWS[i][21:14], ROWS[i][13:6]);
      chk_pins(ROWS[i][5:0]);
    end
    $display("test table done");
    xfer(1'b1, 8'h00, 8'h03);
    rdchk("refused", 8'h00, 8'h00);
    rdchk("status", 8'h0C, 8'h04);
    xfer(1'b1, 8'h0C, 8'h04);
    rdchk("status clr", 8'h0C, 8'h00);
    rdchk("unmapped", 8'h20, 8'h00);
    xfer(1'b1, 8'h08, 8'h00);
    rdchk("armed", 8'h0C, 8'h02);
    rdchk("between", 8'h00, 8'h00);
    xfer(1'b1, 8'h00, 8'h01);
    rdchk("after read", 8'h00, 8'h01);
    $display("test protect done");
    xfer(1'b1, 8'h08, 8'h00);
    sys_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    sys_reset_in <= 1'b0;
    chk_pins(6'h0F);
    xfer(1'b1, 8'h00, 8'h03);
    rdchk("sys reset", 8'h0C, 8'h04);
    pw(8'h00, 8'h03);
    chk_pins(6'h31);
    ext_reset_in <= 1'b1;
    watchdog_irq_in <= 1'b1;
    @(posedge clk_sys_in);
    watchdog_irq_in <= 1'b0;
    ext_reset_in <= 1'b0;
    chk_pins(6'h31);
    watchdog_irq_in <= 1'b1;
    @(posedge clk_sys_in);
    watchdog_irq_in <= 1'b0;
    chk_pins(6'h0E);
    rdchk("allow kept", 8'h00, 8'h01);
    $display("test watchdog done");
    pw(8'h04, 8'h01);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rdchk("subclk por", 8'h04, 8'h00);
    rdchk("ctl por", 8'h00, 8'h00);
    chk_pins(6'h0E);
    $display("test power on done");
    // software entry then exit without external reset
    pw(8'h00, 8'h01);
    pw(8'h04, 8'h01);
    pw(8'h10, 8'h02);
    rdchk("mode", 8'h0C, 8'h01);
    pw(8'h1C, 8'h01);
    chk_pins(6'h30);
    pw(8'h14, 8'h02);
    @(posedge clk_sys_in);
    chk_pins(6'h0E);
    $display("test sequence done");
    stop_test();
  end
endmodule : rbc_top_bench
